// ### rtl/uisalf_pkg.sv
package uisalf_pkg;

  // Register offsets on the parallel bus
  localparam logic [2:0] ADDR_ID   = 3'h2;  // Read side
  localparam logic [2:0] ADDR_FIFO = 3'h2;  // Write side
  localparam logic [2:0] ADDR_LINE = 3'h3;

  // Line format field positions
  localparam int LF_DIV     = 7;
  localparam int LF_BREAK   = 6;
  localparam int LF_PAR_HI  = 5;
  localparam int LF_PAR_LO  = 3;
  localparam int LF_STOP    = 2;
  localparam int LF_WLEN_HI = 1;
  localparam int LF_WLEN_LO = 0;
  localparam logic [7:0] LF_RESET = 8'h00;

  // Fifo setup field positions
  localparam int FS_EN      = 0;
  localparam int FS_RXCLR   = 1;
  localparam int FS_TXCLR   = 2;
  localparam int FS_DMA     = 3;
  localparam int FS_TRIG_LO = 6;
  localparam int FS_TRIG_HI = 7;

  // Identification codes and reset value
  localparam logic [3:0] ID_LINE    = 4'h6;
  localparam logic [3:0] ID_RXDATA  = 4'h4;
  localparam logic [3:0] ID_RXTO    = 4'hC;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [7:0] ID_RESET   = 8'h01;

  // Receive trigger levels
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0E;

  // Parity codes and format values
  localparam logic [2:0] PAR_EVEN_CODE = 3'h3;
  localparam logic [2:0] PAR_ONE_CODE  = 3'h5;
  localparam logic [2:0] PAR_ZERO_CODE = 3'h7;
  localparam logic [3:0] WLEN_BASE     = 4'h5;
  localparam logic [2:0] STOP_ONE      = 3'h2;  // In half bit times
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO      = 3'h4;

  // Pin synchroniser layout
  localparam int SY_W    = 14;
  localparam int SY_DLO  = 0;
  localparam int SY_DHI  = 7;
  localparam int SY_ALO  = 8;
  localparam int SY_AHI  = 10;
  localparam int SY_WR   = 11;
  localparam int SY_RD   = 12;
  localparam int SY_CS   = 13;

  typedef enum logic [1:0] {
    PM_ODD  = 2'h0,
    PM_EVEN = 2'h1,
    PM_ONE  = 2'h2,
    PM_ZERO = 2'h3
  } uisalf_parity_type;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'h1,
    BUS_READ  = 3'h2,
    BUS_WRITE = 3'h4
  } uisalf_bus_type;

endpackage

// ### rtl/uisalf_fmt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface uisalf_fmt_if;
  import uisalf_pkg::*;
  logic [7:0]        line_format;
  logic [3:0]        word_bits;
  logic [2:0]        stop_halves;
  logic              parity_on;
  uisalf_parity_type parity_mode;

  modport ctrl (output line_format, input word_bits, stop_halves, parity_on, parity_mode);
  modport dec  (input line_format, output word_bits, stop_halves, parity_on, parity_mode);
endinterface
`default_nettype wire

// ### rtl/uisalf_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module uisalf_fmt (
  uisalf_fmt_if.dec fmt
);
  import uisalf_pkg::*;

  logic [1:0] wlen;
  logic [2:0] par;

  assign wlen = fmt.line_format[LF_WLEN_HI:LF_WLEN_LO];
  assign par  = fmt.line_format[LF_PAR_HI:LF_PAR_LO];

  // Character length five to eight
  assign fmt.word_bits = WLEN_BASE + {2'h0, wlen};

  // Stop length in half bit times
  always_comb begin
    if (!fmt.line_format[LF_STOP]) begin
      fmt.stop_halves = STOP_ONE;
    end else if (wlen == 2'h0) begin
      fmt.stop_halves = STOP_ONE_HALF;
    end else begin
      fmt.stop_halves = STOP_TWO;
    end
  end

  // Parity selection, forced one moved to code 101
  assign fmt.parity_on = par[0];
  always_comb begin
    case (par)
      PAR_EVEN_CODE: fmt.parity_mode = PM_EVEN;
      PAR_ONE_CODE:  fmt.parity_mode = PM_ONE;
      PAR_ZERO_CODE: fmt.parity_mode = PM_ZERO;
      default:       fmt.parity_mode = PM_ODD;
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/uisalf_top.sv
`timescale 1ns/1ps
`default_nettype none
module uisalf_top (
  input  wire logic                        CORE_CLK,
  input  wire logic                        RESETN,
  input  wire logic [2:0]                  BUS_ADDR,
  input  wire logic                        BUS_CS_N,
  input  wire logic                        BUS_RD_N,
  input  wire logic                        BUS_WR_N,
  input  wire logic [7:0]                  BUS_DATA_IN,
  output logic      [7:0]                  BUS_DATA_OUT,
  output logic                             BUS_DATA_OE_N,
  input  wire logic                        LINE_COND_PEND,
  input  wire logic                        RX_DATA_AVAIL,
  input  wire logic                        RX_TIMEOUT_PEND,
  input  wire logic                        TX_HOLD_EMPTY,
  input  wire logic                        MODEM_CHANGE_PEND,
  input  wire logic [4:0]                  RX_FIFO_LEVEL,
  input  wire logic                        TX_SERIAL_IN,
  output logic                             TX_OUT,
  output logic                             DIV_ACCESS,
  output logic      [3:0]                  WORD_BITS,
  output logic      [2:0]                  STOP_HALVES,
  output logic                             PARITY_ON,
  output uisalf_pkg::uisalf_parity_type    PARITY_MODE,
  output logic                             FIFO_ENABLE,
  output logic                             FIFO_DMA_MODE,
  output logic                             RX_FIFO_CLEAR,
  output logic                             TX_FIFO_CLEAR,
  output logic                             ID_READ_PULSE
);
  import uisalf_pkg::*;

  typedef struct packed {
    // Pin synchroniser stages and filtered pin levels
    logic [SY_W-1:0]   s1;
    logic [SY_W-1:0]   s2;
    logic [SY_W-1:0]   s3;
    logic [SY_W-1:0]   flt;

    // Bus sequencer and captured write
    uisalf_bus_type    bus;
    logic [2:0]        wr_addr;
    logic [7:0]        wr_data;

    // Software visible settings
    logic [7:0]        line_format_control;
    logic              fifo_en;
    logic              dma;
    logic [1:0]        trig;

    // Shown source and read port
    logic [3:0]        id_code;
    logic [7:0]        rdata;
    logic              oe_n;

    // One cycle pulses
    logic              id_rd;
    logic              rx_clr;
    logic              tx_clr;

    // Serial line and decoded format
    logic              tx_out;
    logic [3:0]        word_bits;
    logic [2:0]        stop_halves;
    logic              par_on;
    uisalf_parity_type par_mode;
  } uisalf_state_type;

  uisalf_state_type r_ff;
  uisalf_state_type nxt_r;

  uisalf_fmt_if fmt_bus ();

  logic [4:0] trig_level;
  logic       rx_pend;
  logic       shown_pend;
  logic [3:0] top_code;
  logic [7:0] id_value;
  logic       rd_act;
  logic       wr_act;

  // Format decoder
  assign fmt_bus.line_format = r_ff.line_format_control;
  uisalf_fmt u_fmt (
    .fmt (fmt_bus)
  );

  // Trigger level lookup
  always_comb begin
    case (r_ff.trig)
      2'h0:    trig_level = TRIG_LVL0;
      2'h1:    trig_level = TRIG_LVL1;
      2'h2:    trig_level = TRIG_LVL2;
      default: trig_level = TRIG_LVL3;
    endcase
  end

  // Data available source, fifo mode counts against trigger
  assign rx_pend = r_ff.fifo_en ? (RX_FIFO_LEVEL >= trig_level) : RX_DATA_AVAIL;

  // Highest pending source by fixed priority
  always_comb begin
    if (LINE_COND_PEND) begin
      top_code = ID_LINE;
    end else if (RX_TIMEOUT_PEND) begin
      top_code = ID_RXTO;
    end else if (rx_pend) begin
      top_code = ID_RXDATA;
    end else if (TX_HOLD_EMPTY) begin
      top_code = ID_TXEMPTY;
    end else if (MODEM_CHANGE_PEND) begin
      top_code = ID_MODEM;
    end else begin
      top_code = ID_NONE;
    end
  end

  // Whether the source now shown is still pending
  always_comb begin
    case (r_ff.id_code)
      ID_LINE:    shown_pend = LINE_COND_PEND;
      ID_RXTO:    shown_pend = RX_TIMEOUT_PEND;
      ID_RXDATA:  shown_pend = rx_pend;
      ID_TXEMPTY: shown_pend = TX_HOLD_EMPTY;
      ID_MODEM:   shown_pend = MODEM_CHANGE_PEND;
      default:    shown_pend = 1'b0;
    endcase
  end

  // Id register image, bits 5:4 zero
  assign id_value = {r_ff.fifo_en, r_ff.fifo_en, 2'h0, r_ff.id_code};

  // Filtered strobes
  assign rd_act = !r_ff.flt[SY_CS] && !r_ff.flt[SY_RD];
  assign wr_act = !r_ff.flt[SY_CS] && !r_ff.flt[SY_WR];

  // Next state
  always_comb begin
    nxt_r        = r_ff;
    nxt_r.id_rd  = 1'b0;
    nxt_r.rx_clr = 1'b0;
    nxt_r.tx_clr = 1'b0;

    // Three stage pin synchroniser, a bit moves once stages two and three agree
    nxt_r.s1  = {BUS_CS_N, BUS_RD_N, BUS_WR_N, BUS_ADDR, BUS_DATA_IN};
    nxt_r.s2  = r_ff.s1;
    nxt_r.s3  = r_ff.s2;
    nxt_r.flt = ((r_ff.s2 ~^ r_ff.s3) & r_ff.s3) | ((r_ff.s2 ^ r_ff.s3) & r_ff.flt);

    // Hold the shown source until serviced, then take the next
    if (!shown_pend) begin
      nxt_r.id_code = top_code;
    end

    // Bus access sequence
    case (r_ff.bus)
      BUS_IDLE: begin
        if (rd_act) begin
          nxt_r.bus  = BUS_READ;
          nxt_r.oe_n = 1'b0;
          case (r_ff.flt[SY_AHI:SY_ALO])
            ADDR_ID: begin
              nxt_r.rdata = id_value;
              nxt_r.id_rd = 1'b1;
            end
            ADDR_LINE: nxt_r.rdata = r_ff.line_format_control;
            default:   nxt_r.rdata = 8'h00;
          endcase
        end else if (wr_act) begin
          nxt_r.bus     = BUS_WRITE;
          nxt_r.wr_addr = r_ff.flt[SY_AHI:SY_ALO];
          nxt_r.wr_data = r_ff.flt[SY_DHI:SY_DLO];
        end
      end
      BUS_READ: begin
        if (!rd_act) begin
          nxt_r.bus  = BUS_IDLE;
          nxt_r.oe_n = 1'b1;
        end
      end
      BUS_WRITE: begin
        if (wr_act) begin
          // Track data until the strobe ends
          nxt_r.wr_addr = r_ff.flt[SY_AHI:SY_ALO];
          nxt_r.wr_data = r_ff.flt[SY_DHI:SY_DLO];
        end else begin
          nxt_r.bus = BUS_IDLE;
          if (r_ff.wr_addr == ADDR_LINE) begin
            nxt_r.line_format_control = r_ff.wr_data;
          end else if (r_ff.wr_addr == ADDR_FIFO) begin
            if (r_ff.wr_data[FS_EN]) begin
              nxt_r.fifo_en = 1'b1;
              nxt_r.dma     = r_ff.wr_data[FS_DMA];
              nxt_r.trig    = r_ff.wr_data[FS_TRIG_HI:FS_TRIG_LO];
              nxt_r.rx_clr  = r_ff.wr_data[FS_RXCLR] || !r_ff.fifo_en;
              nxt_r.tx_clr  = r_ff.wr_data[FS_TXCLR] || !r_ff.fifo_en;
            end else begin
              // Leaving fifo mode empties both fifos
              nxt_r.fifo_en = 1'b0;
              nxt_r.rx_clr  = r_ff.fifo_en;
              nxt_r.tx_clr  = r_ff.fifo_en;
            end
          end
        end
      end
      default: begin
        nxt_r.bus  = BUS_IDLE;
        nxt_r.oe_n = 1'b1;
      end
    endcase

    // Break forces the line low
    nxt_r.tx_out = r_ff.line_format_control[LF_BREAK] ? 1'b0 : TX_SERIAL_IN;

    // Registered format outputs
    nxt_r.word_bits   = fmt_bus.word_bits;
    nxt_r.stop_halves = fmt_bus.stop_halves;
    nxt_r.par_on      = fmt_bus.parity_on;
    nxt_r.par_mode    = fmt_bus.parity_mode;
  end

  // State register with synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      // Pins read as idle high
      r_ff.s1          <= '1;
      r_ff.s2          <= '1;
      r_ff.s3          <= '1;
      r_ff.flt         <= '1;

      // Bus idle, nothing captured
      r_ff.bus         <= BUS_IDLE;
      r_ff.wr_addr     <= 3'h0;
      r_ff.wr_data     <= 8'h00;

      // Settings at their defaults
      r_ff.line_format_control         <= LF_RESET;
      r_ff.fifo_en     <= 1'b0;
      r_ff.dma         <= 1'b0;
      r_ff.trig        <= 2'h0;

      // Nothing pending, read port released
      r_ff.id_code     <= ID_RESET[3:0];
      r_ff.rdata       <= 8'h00;
      r_ff.oe_n        <= 1'b1;

      // Pulses low
      r_ff.id_rd       <= 1'b0;
      r_ff.rx_clr      <= 1'b0;
      r_ff.tx_clr      <= 1'b0;

      // Line idle, format of an all zero register
      r_ff.tx_out      <= 1'b1;
      r_ff.word_bits   <= WLEN_BASE;
      r_ff.stop_halves <= STOP_ONE;
      r_ff.par_on      <= 1'b0;
      r_ff.par_mode    <= PM_ODD;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Read port straight from flops
  assign BUS_DATA_OUT  = r_ff.rdata;
  assign BUS_DATA_OE_N = r_ff.oe_n;

  // Serial line and format straight from flops
  assign TX_OUT        = r_ff.tx_out;
  assign DIV_ACCESS    = r_ff.line_format_control[LF_DIV];
  assign WORD_BITS     = r_ff.word_bits;
  assign STOP_HALVES   = r_ff.stop_halves;
  assign PARITY_ON     = r_ff.par_on;
  assign PARITY_MODE   = r_ff.par_mode;

  // Fifo settings straight from flops
  assign FIFO_ENABLE   = r_ff.fifo_en;
  assign FIFO_DMA_MODE = r_ff.dma;

  // Pulses straight from flops
  assign RX_FIFO_CLEAR = r_ff.rx_clr;
  assign TX_FIFO_CLEAR = r_ff.tx_clr;
  assign ID_READ_PULSE = r_ff.id_rd;
endmodule
`default_nettype wire

// ### bench/uisalf_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uisalf_checker (
  input wire logic       CORE_CLK,
  input wire logic       RESETN,
  input wire logic       BUS_CS_N,
  input wire logic       BUS_RD_N,
  input wire logic [7:0] BUS_DATA_OUT,
  input wire logic       BUS_DATA_OE_N,
  input wire logic       TX_SERIAL_IN,
  input wire logic       TX_OUT,
  input wire logic [3:0] WORD_BITS,
  input wire logic [2:0] STOP_HALVES,
  input wire logic       FIFO_ENABLE,
  input wire logic       RX_FIFO_CLEAR,
  input wire logic       TX_FIFO_CLEAR,
  input wire logic       ID_READ_PULSE
);
  import uisalf_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Read strobe held long enough to pass the pin filter
  sequence s_rd_held;
    (!BUS_CS_N && !BUS_RD_N) [*6];
  endsequence
  AST_DRIVE: assert property (s_rd_held |=> !BUS_DATA_OE_N)
    else $error("read strobe held but data not driven");
  AST_RELEASE: assert property ($rose(BUS_DATA_OE_N) |-> $past(BUS_RD_N, 3))
    else $error("data released while read strobe low");
  AST_STAND: assert property (!BUS_DATA_OE_N && $past(!BUS_DATA_OE_N) |-> $stable(BUS_DATA_OUT))
    else $error("read data changed during read");
  AST_PULSE: assert property (ID_READ_PULSE |-> !BUS_DATA_OE_N ##1 !ID_READ_PULSE)
    else $error("id read pulse malformed");
  AST_RSV: assert property (ID_READ_PULSE |-> BUS_DATA_OUT[5:4] == 2'h0)
    else $error("id bits 5:4 not zero");
  AST_FEN: assert property (ID_READ_PULSE |-> BUS_DATA_OUT[7:6] == {2{FIFO_ENABLE}})
    else $error("id bits 7:6 differ from fifo enable");
  AST_NONE: assert property (ID_READ_PULSE && BUS_DATA_OUT[0] |-> BUS_DATA_OUT[3:0] == ID_NONE)
    else $error("no-pending id carries a source code");
  AST_WLEN: assert property (WORD_BITS inside {[4'h5:4'h8]})
    else $error("word length out of range");
  AST_STOP: assert property (STOP_HALVES == STOP_ONE_HALF |-> WORD_BITS == WLEN_BASE)
    else $error("one and a half stops on long word");
  AST_BREAK: assert property ($past(RESETN) && TX_OUT != $past(TX_SERIAL_IN) |-> !TX_OUT)
    else $error("serial out differs from shifter other than break");
  AST_CLR: assert property (RX_FIFO_CLEAR || TX_FIFO_CLEAR |=> !RX_FIFO_CLEAR && !TX_FIFO_CLEAR)
    else $error("fifo clear longer than one cycle");
endmodule
bind uisalf_top uisalf_checker chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .BUS_CS_N(BUS_CS_N),
  .BUS_RD_N(BUS_RD_N), .BUS_DATA_OUT(BUS_DATA_OUT), .BUS_DATA_OE_N(BUS_DATA_OE_N),
  .TX_SERIAL_IN(TX_SERIAL_IN), .TX_OUT(TX_OUT), .WORD_BITS(WORD_BITS),
  .STOP_HALVES(STOP_HALVES), .FIFO_ENABLE(FIFO_ENABLE), .RX_FIFO_CLEAR(RX_FIFO_CLEAR),
  .TX_FIFO_CLEAR(TX_FIFO_CLEAR), .ID_READ_PULSE(ID_READ_PULSE));
`default_nettype wire

// ### bench/uisalf_host.sv
`timescale 1ns/1ps
`default_nettype none
module uisalf_host (
  input  wire logic       clk,
  input  wire logic [7:0] dout,
  input  wire logic       oe_n,
  output var  logic [2:0] addr,
  output var  logic       cs_n,
  output var  logic       rd_n,
  output var  logic       wr_n,
  output var  logic [7:0] din
);
  // Bus idle at time zero
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 3'h0;
    din = 8'h00;
  end
  // Read: hold strobes until the device drives, take data at that edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    {cs_n, rd_n} <= 2'h0;
    do begin
      @(posedge clk);
      n++;
    end while (oe_n !== 1'b0 && n < 20);
    d = (oe_n === 1'b0) ? dout : 8'hXX;  // No answer reads as unknown
    {cs_n, rd_n} <= 2'h3;
    repeat (8) @(posedge clk);
    addr <= ~a;  // Released lines wander
  endtask
  // Write: data held well past the strobe so the filtered commit sees it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    din <= d;
    {cs_n, wr_n} <= 2'h0;
    repeat (6) @(posedge clk);
    {cs_n, wr_n} <= 2'h3;
    repeat (8) @(posedge clk);
    addr <= ~a;
    din <= ~d;
  endtask
endmodule
`default_nettype wire

// ### bench/uart_irq_status_and_line_format_test.sv
`timescale 1ns/1ps
`default_nettype none
module uart_irq_status_and_line_format_test;
  import uisalf_pkg::*;
  localparam logic [3:0] CODES [6] = '{ID_LINE, ID_RXTO, ID_RXDATA, ID_TXEMPTY, ID_MODEM, ID_NONE};
  localparam logic [7:0] LCRS [7] = '{8'h0F, 8'h1D, 8'h2C, 8'h3B, 8'h86, 8'h31, 8'h00};
  localparam logic [4:0] TRIGS [4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, TRIG_LVL3};
  logic              core_clk;
  logic              resetn     = 1'b0;
  logic [4:0]        src        = 5'h00;  // Line, time-out, data, tx empty, modem
  logic [4:0]        lvl        = 5'h00;
  logic              ser        = 1'b1;
  logic [2:0]        addr;
  logic              cs_n, rd_n, wr_n, oe_n, tx_out, div_acc, par_on, fen, dma;
  logic              rxc, txc, idp;
  logic [7:0]        n_clr      = 8'h00;
  logic [7:0]        n_idp      = 8'h00;
  logic [7:0]        din, dout, rv;
  logic [3:0]        wbits;
  logic [2:0]        stops;
  uisalf_parity_type pmode;
  int                mismatches = 0;
  int                num_checks = 0;
  int                cycles     = 0;
  uisalf_host host (.clk(core_clk), .dout(dout), .oe_n(oe_n), .addr(addr), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .din(din));
  uisalf_top uut (.CORE_CLK(core_clk), .RESETN(resetn), .BUS_ADDR(addr), .BUS_CS_N(cs_n),
    .BUS_RD_N(rd_n), .BUS_WR_N(wr_n), .BUS_DATA_IN(din), .BUS_DATA_OUT(dout),
    .BUS_DATA_OE_N(oe_n), .LINE_COND_PEND(src[4]), .RX_DATA_AVAIL(src[2]),
    .RX_TIMEOUT_PEND(src[3]), .TX_HOLD_EMPTY(src[1]), .MODEM_CHANGE_PEND(src[0]),
    .RX_FIFO_LEVEL(lvl), .TX_SERIAL_IN(ser), .TX_OUT(tx_out), .DIV_ACCESS(div_acc),
    .WORD_BITS(wbits), .STOP_HALVES(stops), .PARITY_ON(par_on), .PARITY_MODE(pmode),
    .FIFO_ENABLE(fen), .FIFO_DMA_MODE(dma), .RX_FIFO_CLEAR(rxc), .TX_FIFO_CLEAR(txc),
    .ID_READ_PULSE(idp));
  // Count pulses seen on the outputs
  always @(posedge core_clk) begin
    if (rxc === 1'b1 && txc === 1'b1) n_clr <= n_clr + 8'h01;
    if (idp === 1'b1) n_idp <= n_idp + 8'h01;
  end
  // Clock at 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic drv(input logic [4:0] s, input logic [4:0] l);
    @(posedge core_clk);
    src <= s;
    lvl <= l;
  endtask
  function automatic logic [2:0] exp_stop(input logic [7:0] l);
    return !l[2] ? 3'h2 : (l[1:0] == 2'h0 ? 3'h3 : 3'h4);
  endfunction
  function automatic logic [1:0] exp_par(input logic [7:0] l);
    return l[5:4] == 2'h3 ? 2'h3 : (l[5:4] == 2'h2 ? 2'h2 : {1'b0, l[4]});
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({oe_n, tx_out, div_acc, par_on}, 8'h0C);
    chk({wbits, 1'b0, stops}, 8'h52);
    host.rd(ADDR_ID, rv);
    chk(rv, ID_RESET);
    host.rd(ADDR_LINE, rv);
    chk(rv, LF_RESET);
    chk(n_idp, 8'h01);
    $display("reset test done");
    drv(5'h1F, 5'h00);
    for (int i = 0; i < 6; i++) begin
      host.rd(ADDR_ID, rv);
      chk(rv, {4'h0, CODES[i]});
      drv(src & ~(5'h10 >> i), 5'h00);
    end
    drv(5'h02, 5'h00);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'h02);
    drv(5'h12, 5'h00);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'h02);
    drv(5'h10, 5'h00);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'h06);
    drv(5'h00, 5'h00);
    $display("priority test done");
    foreach (LCRS[i]) begin
      host.wr(ADDR_LINE, LCRS[i]);
      host.rd(ADDR_LINE, rv);
      chk(rv, LCRS[i]);
      chk(div_acc, LCRS[i][7]);
      chk(wbits, 4'h5 + LCRS[i][1:0]);
      chk(stops, exp_stop(LCRS[i]));
      chk(par_on, LCRS[i][3]);
      if (LCRS[i][3]) chk(pmode, exp_par(LCRS[i]));
    end
    $display("format test done");
    host.wr(ADDR_LINE, 8'h43);
    chk(tx_out, 1'b0);
    repeat (20) @(posedge core_clk);
    chk(tx_out, 1'b0);
    host.wr(ADDR_LINE, 8'h03);
    chk(tx_out, 1'b1);
    @(posedge core_clk);
    ser <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(tx_out, 1'b0);
    ser <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(tx_out, 1'b1);
    host.wr(3'h6, 8'hFF);
    host.rd(ADDR_LINE, rv);
    chk(rv, 8'h03);
    host.rd(3'h5, rv);
    chk(rv, 8'h00);
    $display("break test done");
    host.wr(ADDR_FIFO, 8'hC9);
    chk({fen, dma}, 8'h03);
    chk(n_clr, 8'h01);
    drv(5'h00, 5'h0D);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'hC1);
    drv(5'h00, 5'h0E);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'hC4);
    foreach (TRIGS[i]) begin
      host.wr(ADDR_FIFO, {2'(i), 6'h09});
      drv(5'h00, TRIGS[i] - 5'h01);
      host.rd(ADDR_ID, rv);
      chk(rv, 8'hC1);
      drv(5'h00, TRIGS[i]);
      host.rd(ADDR_ID, rv);
      chk(rv, 8'hC4);
    end
    drv(5'h00, 5'h00);
    host.wr(ADDR_FIFO, 8'h00);
    chk({fen, dma}, 8'h01);
    chk(n_clr, 8'h02);
    host.rd(ADDR_ID, rv);
    chk(rv, 8'h01);
    $display("fifo test done");
    final_report();
  end
endmodule
`default_nettype wire
